// *** design/watch_timer.sv ***
// Watch and interval timer with AXI4-Lite register access
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module watch_timer
    import watch_timer_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address channel
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    // Write data channel
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [DATA_W/8-1:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // Write response channel
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read address channel
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    // Read data channel
    output logic [DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Interrupt requests
    output logic watch_irq,
    output logic interval_irq
);
    // Control register
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;

    // Write channel state
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic aw_have_q;
    logic w_have_q;
    logic [ADDR_W-1:0] waddr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [DATA_W/8-1:0] wstrb_q;

    // Read channel state
    logic arready_q;
    logic rvalid_q;
    logic [DATA_W-1:0] rdata_q;
    logic [1:0] rresp_q;

    // Request outputs
    logic watch_irq_q;
    logic interval_irq_q;

    // Handshake and decode wires
    logic aw_fire;
    logic w_fire;
    logic b_fire;
    logic ar_fire;
    logic r_fire;
    logic aw_now;
    logic w_now;
    logic do_write;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [DATA_W/8-1:0] wr_strb;
    logic wr_ctrl;
    logic wr_bitop;
    logic wr_status;
    logic wr_hit;
    logic rd_ctrl;
    logic rd_bitop;
    logic rd_status;
    logic rd_hit;
    logic [DATA_W-1:0] rd_word;
    logic [2:0] bit_sel;
    logic bit_val;
    logic [7:0] bit_mask;

    // Protection bits carry no meaning here
    logic unused_prot;
    assign unused_prot = ^{awprot, arprot};

    watch_link_if lnk ();

    watch_prescaler watch_prescaler_inst (
        .aclk(aclk),
        .aresetn(aresetn),
        .lnk(lnk)
    );

    watch_counter watch_counter_inst (
        .aclk(aclk),
        .aresetn(aresetn),
        .lnk(lnk)
    );

    // Control fields onto the link
    assign lnk.run = ctrl_q[ENABLE_BIT];
    assign lnk.start = ctrl_q[START_BIT];
    assign lnk.clk_sel = ctrl_q[CLK_SEL_BIT];
    assign lnk.ival_sel = ctrl_q[IVAL_LSB +: 3];
    assign lnk.wsel = ctrl_q[WSEL_LSB +: 2];

    // Channel handshakes
    assign aw_fire = awvalid && awready_q;
    assign w_fire = wvalid && wready_q;
    assign b_fire = bvalid_q && bready;
    assign ar_fire = arvalid && arready_q;
    assign r_fire = rvalid_q && rready;

    // Address and data may arrive in either order or together
    assign aw_now = aw_have_q || aw_fire;
    assign w_now = w_have_q || w_fire;
    assign do_write = aw_now && w_now && !bvalid_q;
    assign wr_addr = aw_have_q ? waddr_q : awaddr;
    assign wr_data = w_have_q ? wdata_q : wdata;
    assign wr_strb = w_have_q ? wstrb_q : wstrb;

    // Write decode; status is read-only but still mapped
    assign wr_ctrl = wr_addr[ADDR_W-1:2] == CTRL_ADDR[ADDR_W-1:2];
    assign wr_bitop = wr_addr[ADDR_W-1:2] == BITOP_ADDR[ADDR_W-1:2];
    assign wr_status = wr_addr[ADDR_W-1:2] == STATUS_ADDR[ADDR_W-1:2];
    assign wr_hit = wr_ctrl || wr_bitop || wr_status;

    // Single-bit operation: index and new value
    assign bit_sel = wr_data[BITOP_IDX_LSB +: 3];
    assign bit_val = wr_data[BITOP_VAL_BIT];
    assign bit_mask = 8'h01 << bit_sel;

    // Next control value
    always_comb begin
        ctrl_d = ctrl_q;
        if (do_write && wr_strb[0]) begin
            if (wr_ctrl) begin
                ctrl_d = wr_data[7:0];
            end else if (wr_bitop) begin
                ctrl_d = bit_val ? (ctrl_q | bit_mask)
                                 : (ctrl_q & ~bit_mask);
            end
        end
    end

    // Read decode
    assign rd_ctrl = araddr[ADDR_W-1:2] == CTRL_ADDR[ADDR_W-1:2];
    assign rd_bitop = araddr[ADDR_W-1:2] == BITOP_ADDR[ADDR_W-1:2];
    assign rd_status = araddr[ADDR_W-1:2] == STATUS_ADDR[ADDR_W-1:2];
    assign rd_hit = rd_ctrl || rd_bitop || rd_status;
    assign rd_word = rd_ctrl ? {24'h000000, ctrl_q}
        : rd_status ? {16'h0000, lnk.pre_val, lnk.cnt_val}
        : 32'h00000000;

    // Control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // Address and data holding until both are present
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            waddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
            end else begin
                if (aw_fire) begin
                    aw_have_q <= 1'b1;
                    waddr_q <= awaddr;
                end
                if (w_fire) begin
                    w_have_q <= 1'b1;
                    wdata_q <= wdata;
                    wstrb_q <= wstrb;
                end
            end
        end
    end

    // Write ready and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            if (aw_fire) begin
                awready_q <= 1'b0;
            end else if (!aw_have_q && !bvalid_q && !do_write) begin
                awready_q <= 1'b1;
            end
            if (w_fire) begin
                wready_q <= 1'b0;
            end else if (!w_have_q && !bvalid_q && !do_write) begin
                wready_q <= 1'b1;
            end
            if (do_write) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (b_fire) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Read channel: one read at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (ar_fire) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (r_fire) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end else if (!rvalid_q) begin
            arready_q <= 1'b1;
        end
    end

    // Request pulses, registered so outputs come from flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            watch_irq_q <= 1'b0;
            interval_irq_q <= 1'b0;
        end else begin
            watch_irq_q <= lnk.watch_tick;
            interval_irq_q <= lnk.interval_tick;
        end
    end

    // Outputs
    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign watch_irq = watch_irq_q;
    assign interval_irq = interval_irq_q;
endmodule
`default_nettype wire

// *** pkg/watch_timer_pkg.sv ***
// Constants, field layout and shared decode for the watch timer
package watch_timer_pkg;

    // Bus geometry
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;

    // Register indices; byte address is four times the index
    localparam logic [15:0] CTRL_IDX = 16'hFF41;
    localparam logic [15:0] BITOP_IDX = 16'hFF43;
    localparam logic [15:0] STATUS_IDX = 16'hFF44;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] BITOP_ADDR = {BITOP_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] STATUS_ADDR = {STATUS_IDX, 2'b00};

    // Control register fields
    localparam int CLK_SEL_BIT = 7;
    localparam int IVAL_LSB = 4;
    localparam int WSEL_LSB = 2;
    localparam int START_BIT = 1;
    localparam int ENABLE_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Single-bit operation fields
    localparam int BITOP_VAL_BIT = 7;
    localparam int BITOP_IDX_LSB = 0;

    // Responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timing: watch clock is the system clock over 2^7 or 2^6
    localparam int DIV_SLOW_LOG = 7;
    localparam int DIV_FAST_LOG = 6;
    localparam int PRE_WIDTH = 11;
    localparam int CNT_WIDTH = 5;
    localparam int IVAL_BASE_LOG = 4;
    localparam int CNT_TAP_LOG = 9;
    localparam int SHORT_LONG_LOG = 5;
    localparam int SHORT_SHORT_LOG = 4;
    localparam logic [4:0] CNT_WRAP_FULL = 5'h1F;
    localparam logic [3:0] CNT_WRAP_HALF = 4'hF;

    // True when the low n bits of v are all ones
    function automatic logic low_ones(input logic [15:0] v, input int n);
        logic r;
        r = 1'b1;
        for (int i = 0; i < 16; i++) begin
            if (i < n && !v[i]) begin
                r = 1'b0;
            end
        end
        return r;
    endfunction

endpackage

// *** pkg/watch_link_if.sv ***
// Signals between the control block, prescaler and watch counter
`timescale 1ns/100ps
`default_nettype none
interface watch_link_if;
    import watch_timer_pkg::*;
    logic run;
    logic clk_sel;
    logic start;
    logic [2:0] ival_sel;
    logic [1:0] wsel;
    logic pre_tick;
    logic interval_tick;
    logic short_tick;
    logic watch_tick;
    logic [PRE_WIDTH-1:0] pre_val;
    logic [CNT_WIDTH-1:0] cnt_val;

    modport ctrl (output run, clk_sel, start, ival_sel, wsel,
        input pre_tick, interval_tick, short_tick, watch_tick,
        pre_val, cnt_val);
    modport pre (input run, clk_sel, ival_sel, wsel,
        output pre_tick, interval_tick, short_tick, pre_val);
    modport cnt (input run, start, wsel, pre_tick, short_tick,
        output watch_tick, cnt_val);
endinterface
`default_nettype wire

// *** design/watch_prescaler.sv ***
// Watch clock divider and 11-bit prescaler with its taps
`timescale 1ns/100ps
`default_nettype none
module watch_prescaler
    import watch_timer_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Link to control and counter
    watch_link_if.pre lnk
);
    logic [DIV_SLOW_LOG-1:0] div_q;
    logic [PRE_WIDTH-1:0] pre_q;
    logic wclk_tick;
    logic [3:0] ival_log;
    logic [3:0] short_log;

    // watch clock over 128 or 64
    assign wclk_tick = lnk.clk_sel ? low_ones(16'(div_q), DIV_FAST_LOG)
                                   : low_ones(16'(div_q), DIV_SLOW_LOG);
    assign ival_log = 4'(IVAL_BASE_LOG) + {1'b0, lnk.ival_sel};
    assign short_log = lnk.wsel[0] ? 4'(SHORT_SHORT_LOG)
                                   : 4'(SHORT_LONG_LOG);
    assign lnk.interval_tick = lnk.run && wclk_tick
        && low_ones(16'(pre_q), int'(ival_log));
    assign lnk.pre_tick = lnk.run && wclk_tick
        && low_ones(16'(pre_q), CNT_TAP_LOG);
    assign lnk.short_tick = lnk.run && wclk_tick
        && low_ones(16'(pre_q), int'(short_log));
    assign lnk.pre_val = pre_q;

    always_ff @(posedge aclk) begin
        if (!aresetn || !lnk.run) begin
            div_q <= '0;
            pre_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
            if (wclk_tick) begin
                pre_q <= pre_q + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// *** design/watch_counter.sv ***
// Five-bit watch counter clocked by the prescaler output
`timescale 1ns/100ps
`default_nettype none
module watch_counter
    import watch_timer_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Link to control and prescaler
    watch_link_if.cnt lnk
);
    logic [CNT_WIDTH-1:0] cnt_q;
    logic armed_q;
    logic counting;
    logic wrap;

    // counts only with enable and start
    assign counting = lnk.run && lnk.start;
    // period select 2^14, 2^13, 2^5, 2^4
    assign wrap = lnk.wsel[0] ? (cnt_q[3:0] == CNT_WRAP_HALF)
                              : (cnt_q == CNT_WRAP_FULL);
    assign lnk.watch_tick = counting && armed_q
        && (lnk.wsel[1] ? lnk.short_tick : (lnk.pre_tick && wrap));
    assign lnk.cnt_val = cnt_q;

    always_ff @(posedge aclk) begin
        if (!aresetn || !counting) begin
            cnt_q <= '0;
            armed_q <= 1'b0;
        end else if (lnk.pre_tick) begin
            if (!armed_q) begin
                armed_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// *** testbench/watch_timer_checker.sv ***
// Port-level assertions for the watch timer
`timescale 1ns/100ps
`default_nettype none
module watch_timer_checker
    import watch_timer_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [1:0] rresp,
    input wire logic [DATA_W-1:0] rdata,
    // Requests
    input wire logic watch_irq,
    input wire logic interval_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_w_both;
        awvalid && awready && wvalid && wready;
    endsequence
    // Write readies return one cycle after the response drops
    sequence s_b_done;
        !bvalid ##1 (awready && wready);
    endsequence
    sequence s_r_done;
        !rvalid ##1 arready;
    endsequence
    // Shortest interval period is far above eight cycles
    sequence s_ival_quiet;
        !interval_irq [*8];
    endsequence
    a_b_answer: assert property (s_w_both |=> bvalid)
        else $error("write not answered");
    a_b_release: assert property (bvalid && bready |=> s_b_done)
        else $error("write channel not reopened");
    a_r_answer: assert property (arvalid && arready
        |=> rvalid && !arready)
        else $error("read not answered");
    a_r_release: assert property (rvalid && rready |=> s_r_done)
        else $error("read channel not reopened");
    a_slverr_zero: assert property (rvalid && rresp == RESP_SLVERR
        |-> rdata == '0)
        else $error("unmapped read returned data");
    a_watch_pulse: assert property (watch_irq |=> !watch_irq)
        else $error("watch request longer than a cycle");
    a_ival_pulse: assert property (interval_irq |=> s_ival_quiet)
        else $error("interval request repeats too soon");
    a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
        !bvalid && !rvalid && !watch_irq && !interval_irq)
        else $error("outputs active after reset");
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the watch timer over its register bus
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
    import watch_timer_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, watch_irq, interval_irq;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int n_fail = 0;
    int cmp_count = 0;
    int g, wc, ic;

    watch_timer watch_timer_inst (.aclk, .aresetn, .awaddr, .awprot(3'h0),
        .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
        .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .watch_irq, .interval_irq);

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d,
        input logic [1:0] er);
        logic got;
        got = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 50 && !got; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) got = 1'b1;
        end
        bready <= 1'b0;
        `CHK(got, 1'b1)
        `CHK(bresp, er)
    endtask

    task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [1:0] er);
        logic got;
        got = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 50 && !got; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                got = 1'b1;
                rd = rdata;
                `CHK(rresp, er)
            end
        end
        rready <= 1'b0;
        `CHK(got, 1'b1)
    endtask

    // Cycles from one request pulse to the next
    task automatic gap(input bit w, output int n);
        n = 0;
        while (n < 40000 && (w ? watch_irq : interval_irq) !== 1'b1) begin
            @(posedge aclk);
            n++;
        end
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (n < 40000 && (w ? watch_irq : interval_irq) !== 1'b1);
    endtask

    task automatic cnt(input int n);
        wc = 0;
        ic = 0;
        repeat (n) begin
            @(posedge aclk);
            if (watch_irq) wc++;
            if (interval_irq) ic++;
        end
    endtask

    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'hF;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd_reg(CTRL_ADDR, RESP_OKAY);
        `CHK(rd, 32'h00000000)
        rd_reg(STATUS_ADDR, RESP_OKAY);
        `CHK(rd, 32'h00000000)
        wr(18'h00010, 8'hFF, RESP_SLVERR);
        rd_reg(18'h00010, RESP_SLVERR);
        for (int c = 0; c < 3; c++) begin
            wr(CTRL_ADDR, 8'h81 | 8'(c << 4), RESP_OKAY);
            gap(0, g);
            `CHK(g, 1024 << c)
        end
        wr(CTRL_ADDR, 8'h01, RESP_OKAY);
        gap(0, g);
        `CHK(g, 2048)
        // Disabled timer must stay silent and cleared
        wr(CTRL_ADDR, 8'h00, RESP_OKAY);
        cnt(3000);
        `CHK(wc + ic, 0)
        rd_reg(STATUS_ADDR, RESP_OKAY);
        `CHK(rd, 32'h00000000)
        wr(CTRL_ADDR, 8'hBD, RESP_OKAY);
        wr(BITOP_ADDR, 8'h81, RESP_OKAY);
        rd_reg(CTRL_ADDR, RESP_OKAY);
        `CHK(rd, 32'h000000BF)
        gap(1, g);
        `CHK(g, 1024)
        wr(BITOP_ADDR, 8'h02, RESP_OKAY);
        rd_reg(CTRL_ADDR, RESP_OKAY);
        `CHK(rd, 32'h000000BB)
        gap(1, g);
        `CHK(g, 2048)
        cnt(8192);
        `CHK(wc, 4)
        `CHK(ic, 1)
        // Stopping the counter leaves the prescaler running
        wr(BITOP_ADDR, 8'h01, RESP_OKAY);
        rd_reg(STATUS_ADDR, RESP_OKAY);
        `CHK(rd[4:0], 5'h00)
        cnt(8192);
        `CHK(wc, 0)
        `CHK(ic, 1)
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd_reg(CTRL_ADDR, RESP_OKAY);
        `CHK(rd, 32'h00000000)
        test_done;
    end

    // Tests need about 75000 cycles; cap stays under 100000
    initial begin
        repeat (95000) @(posedge aclk);
        n_fail++;
        test_done;
    end
endmodule
bind watch_timer watch_timer_checker watch_timer_checker_inst (.aclk,
    .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
    .arvalid, .arready, .rvalid, .rready, .rresp, .rdata, .watch_irq,
    .interval_irq);
`default_nettype wire
